// ### rtl/ssc_defines.svh
// Purpose: constants for the host-side controller of a 16K x 4 async static memory
// Assumes: 200 MHz core clock, 5 ns period
// Notes: device times in ns, clock period in ps, cycle counts derived from them
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH

`define SSC_ADDR_W 14
`define SSC_DATA_W 4
`define SSC_CLK_PS 5000
`define SSC_WRITE_PULSE_NS 10
`define SSC_WRITE_RECOVERY_NS 1
`define SSC_READ_ACCESS_NS 15
`define SSC_DESELECT_TO_HIGH_IMPEDANCE_NS 6
`define SSC_DATA_TO_WRITE_END_NS 9
`define SSC_DATA_HOLD_AFTER_WRITE_NS 0
// Least times round up to whole cycles, never below one
`define SSC_CYC_UP(ns) (((ns) * 1000 + `SSC_CLK_PS - 1) / `SSC_CLK_PS)
`define SSC_WRITE_PULSE_CYC `SSC_CYC_UP(`SSC_WRITE_PULSE_NS)
`define SSC_WRITE_RECOVERY_CYC `SSC_CYC_UP(`SSC_WRITE_RECOVERY_NS)
`define SSC_READ_ACCESS_CYC (`SSC_CYC_UP(`SSC_READ_ACCESS_NS) + 1)
`define SSC_TURNAROUND_CYC `SSC_CYC_UP(`SSC_DESELECT_TO_HIGH_IMPEDANCE_NS)
`define SSC_CNT_W 4

`endif

// ### rtl/ssc_pkg.sv
// Purpose: types for the static memory host controller
// Assumes: ssc_defines.svh included first
// Notes: request and pin bundles as packed structs
`include "ssc_defines.svh"

package ssc_pkg;

    typedef struct packed {
        logic [`SSC_ADDR_W-1:0] addr;
        logic [`SSC_DATA_W-1:0] wdata;
        logic write;
    } ssc_req_t;

    typedef struct packed {
        logic [`SSC_ADDR_W-1:0] addr;
        logic select_n;
        logic write_n;
        logic [`SSC_DATA_W-1:0] dout;
        logic doe;
    } ssc_pins_t;

    typedef enum logic [5:0] {
        SSC_IDLE = 6'b000001,
        SSC_RSET = 6'b000010,
        SSC_RACC = 6'b000100,
        SSC_WSET = 6'b001000,
        SSC_WPUL = 6'b010000,
        SSC_GAP  = 6'b100000
    } ssc_state_t;

endpackage

// ### rtl/ssc_timer.sv
// Purpose: down counter that times the read access, write pulse and gap phases
// Assumes: load and run never asked in the same cycle as expiry matters
// Notes: done is high while the count is zero
`timescale 1ns/1ps
`include "ssc_defines.svh"

module ssc_timer
    import ssc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Control
    input wire logic load_i,
    input wire logic [`SSC_CNT_W-1:0] value_i,
    // Status
    output logic done_o
);

    logic [`SSC_CNT_W-1:0] count_ff;
    logic [`SSC_CNT_W-1:0] nxt_count;

    always_comb
    begin
        nxt_count = count_ff;
        if (load_i)
        begin
            nxt_count = value_i;
        end
        else if (count_ff != '0)
        begin
            nxt_count = count_ff - 4'h1;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            count_ff <= 4'h0;
        end
        else
        begin
            count_ff <= nxt_count;
        end
    end

    assign done_o = (count_ff == 4'h0);

endmodule // ssc_timer

// ### rtl/ssc_host.sv
// Purpose: host-side controller driving a 16K x 4 asynchronous static memory
// Assumes: memory pins sampled synchronously to core_clk_i
// Notes: one access at a time; address held steady through every phase
`timescale 1ns/1ps
`include "ssc_defines.svh"

module ssc_host
    import ssc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // User request port
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [`SSC_ADDR_W-1:0] req_addr_i,
    input wire logic [`SSC_DATA_W-1:0] req_wdata_i,
    output logic req_ready_o,
    // User read answer
    output logic rsp_valid_o,
    output logic [`SSC_DATA_W-1:0] rsp_rdata_o,
    // Memory pins
    output logic [`SSC_ADDR_W-1:0] mem_addr_o,
    output logic mem_select_n_o,
    output logic mem_write_n_o,
    output logic [`SSC_DATA_W-1:0] mem_data_o,
    output logic mem_data_oe_o,
    input wire logic [`SSC_DATA_W-1:0] mem_data_i
);

    ssc_state_t state_ff;
    ssc_state_t nxt_state;
    ssc_req_t req_ff;
    ssc_req_t nxt_req;
    ssc_pins_t pins_ff;
    ssc_pins_t nxt_pins;
    logic ready_ff;
    logic nxt_ready;
    logic rsp_valid_ff;
    logic nxt_rsp_valid;
    logic [`SSC_DATA_W-1:0] rdata_ff;
    logic [`SSC_DATA_W-1:0] nxt_rdata;
    logic tmr_load;
    logic [`SSC_CNT_W-1:0] tmr_value;
    logic tmr_done;

    function automatic logic [`SSC_CNT_W-1:0] cyc(input int n);
        cyc = (n < 1) ? 4'h1 : n[`SSC_CNT_W-1:0];
    endfunction

    // Taking edge: idle, ready shown and a request present
    function automatic logic take_req(input ssc_state_t st, input logic valid,
        input logic rdy);
        take_req = (st == SSC_IDLE) && valid && rdy;
    endfunction

    // Last cycle of the read access window
    function automatic logic read_done(input ssc_state_t st, input logic done);
        read_done = (st == SSC_RACC) && done;
    endfunction

    ssc_timer u_timer (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .load_i(tmr_load),
        .value_i(tmr_value),
        .done_o(tmr_done)
    );

    always_comb
    begin
        nxt_state = state_ff;
        nxt_pins = pins_ff;
        nxt_ready = 1'b0;
        tmr_load = 1'b0;
        tmr_value = 4'h0;
        case (state_ff)
            SSC_IDLE:
            begin
                nxt_ready = 1'b1;
                if (take_req(state_ff, req_valid_i, ready_ff))
                begin
                    nxt_ready = 1'b0;
                    // Address goes out one cycle before select falls
                    nxt_pins.addr = req_addr_i;
                    nxt_pins.write_n = 1'b1;
                    nxt_state = req_write_i ? SSC_WSET : SSC_RSET;
                end
            end
            SSC_RSET:
            begin
                nxt_pins.select_n = 1'b0;
                nxt_pins.doe = 1'b0;
                tmr_load = 1'b1;
                tmr_value = cyc(`SSC_READ_ACCESS_CYC);
                nxt_state = SSC_RACC;
            end
            SSC_RACC:
            begin
                if (read_done(state_ff, tmr_done))
                begin
                    nxt_pins.select_n = 1'b1;
                    // Bus float time before host may drive again
                    tmr_load = 1'b1;
                    tmr_value = cyc(`SSC_TURNAROUND_CYC);
                    nxt_state = SSC_GAP;
                end
            end
            SSC_WSET:
            begin
                // Strobe falls with select so device outputs stay floating
                nxt_pins.select_n = 1'b0;
                nxt_pins.write_n = 1'b0;
                nxt_pins.dout = req_ff.wdata;
                nxt_pins.doe = 1'b1;
                tmr_load = 1'b1;
                tmr_value = cyc(`SSC_WRITE_PULSE_CYC);
                nxt_state = SSC_WPUL;
            end
            SSC_WPUL:
            begin
                // Address and data untouched while both strobes low
                if (tmr_done)
                begin
                    // Both rise together; device stays floating after
                    nxt_pins.select_n = 1'b1;
                    nxt_pins.write_n = 1'b1;
                    nxt_pins.doe = 1'b0;
                    tmr_load = 1'b1;
                    tmr_value = cyc(`SSC_WRITE_RECOVERY_CYC);
                    nxt_state = SSC_GAP;
                end
            end
            SSC_GAP:
            begin
                // Address held until recovery ends, then next may change it
                if (tmr_done)
                begin
                    nxt_ready = 1'b1;
                    nxt_state = SSC_IDLE;
                end
            end
            default:
            begin
                nxt_state = SSC_IDLE;
                nxt_pins.select_n = 1'b1;
                nxt_pins.write_n = 1'b1;
                nxt_pins.doe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_ff <= SSC_IDLE;
            pins_ff <= '{addr: 14'h0000, select_n: 1'b1, write_n: 1'b1, dout: 4'h0,
                         doe: 1'b0};
            ready_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            pins_ff <= nxt_pins;
            ready_ff <= nxt_ready;
        end
    end

    // Request latch: only the taking edge loads it, so write data stays put
    always_comb
    begin
        nxt_req = req_ff;
        if (take_req(state_ff, req_valid_i, ready_ff))
        begin
            nxt_req.addr = req_addr_i;
            nxt_req.wdata = req_wdata_i;
            nxt_req.write = req_write_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            req_ff <= '0;
        end
        else
        begin
            req_ff <= nxt_req;
        end
    end

    // Read answer: sampled once, at the far end of the access window
    always_comb
    begin
        nxt_rsp_valid = 1'b0;
        nxt_rdata = rdata_ff;
        if (read_done(state_ff, tmr_done))
        begin
            nxt_rdata = mem_data_i;
            nxt_rsp_valid = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rsp_valid_ff <= 1'b0;
            rdata_ff <= 4'h0;
        end
        else
        begin
            rsp_valid_ff <= nxt_rsp_valid;
            rdata_ff <= nxt_rdata;
        end
    end

    assign req_ready_o = ready_ff;
    assign rsp_valid_o = rsp_valid_ff;
    assign rsp_rdata_o = rdata_ff;
    assign mem_addr_o = pins_ff.addr;
    assign mem_select_n_o = pins_ff.select_n;
    assign mem_write_n_o = pins_ff.write_n;
    assign mem_data_o = pins_ff.dout;
    assign mem_data_oe_o = pins_ff.doe;

endmodule // ssc_host

// ### test/ssc_host_assertions.sv
// Purpose: pin checks of the memory host controller
// Assumes: bound to ssc_host, cycle figures follow its phase counters
// Notes: one clock domain, so default clocking
`timescale 1ns/1ps
module ssc_host_assertions
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // User side
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [13:0] req_addr_i,
    input wire logic [3:0] req_wdata_i,
    input wire logic req_ready_o,
    input wire logic rsp_valid_o,
    input wire logic [3:0] rsp_rdata_o,
    // Memory side
    input wire logic [13:0] mem_addr_o,
    input wire logic mem_select_n_o,
    input wire logic mem_write_n_o,
    input wire logic [3:0] mem_data_o,
    input wire logic mem_data_oe_o,
    input wire logic [3:0] mem_data_i
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    chk_read_strobe: assert property (
        !mem_select_n_o && !mem_data_oe_o |-> mem_write_n_o) else $error("strobe in read");
    // Strobes low three cycles, 15 ns against the 10 ns floor
    chk_pulse_width: assert property ($fell(mem_write_n_o) |->
        (!mem_select_n_o && !mem_write_n_o)[*3] ##1 mem_select_n_o && mem_write_n_o)
        else $error("write pulse");
    chk_data_setup: assert property ($fell(mem_write_n_o) |->
        mem_data_oe_o ##1 mem_data_oe_o && $stable(mem_data_o)) else $error("write data");
    chk_addr_steady: assert property (
        !mem_select_n_o |-> $stable(mem_addr_o)) else $error("address moved");
    chk_host_release: assert property (
        mem_data_oe_o |-> !mem_write_n_o && !mem_select_n_o) else $error("host drives");
    chk_write_recovery: assert property (
        $rose(mem_write_n_o) |-> mem_select_n_o ##1 mem_select_n_o) else $error("recovery");
    // Select low five cycles: access time plus two cycles of margin
    chk_read_span: assert property ($fell(mem_select_n_o) && mem_write_n_o |->
        (!mem_select_n_o && mem_write_n_o)[*5] ##1 mem_select_n_o) else $error("read span");
    chk_answer_time: assert property (
        req_valid_i && req_ready_o && !req_write_i |-> ##7 rsp_valid_o) else $error("late");
    chk_read_data: assert property (
        rsp_valid_o |-> rsp_rdata_o == $past(mem_data_i)) else $error("read data");
    cov_read: cover property (rsp_valid_o);
    cov_write: cover property ($fell(mem_write_n_o));
    cov_refused: cover property (req_valid_i && !req_ready_o);
endmodule // ssc_host_assertions
bind ssc_host ssc_host_assertions u_chk (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .req_valid_i(req_valid_i),
    .req_write_i(req_write_i),
    .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i),
    .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o),
    .mem_addr_o(mem_addr_o),
    .mem_select_n_o(mem_select_n_o),
    .mem_write_n_o(mem_write_n_o),
    .mem_data_o(mem_data_o),
    .mem_data_oe_o(mem_data_oe_o),
    .mem_data_i(mem_data_i)
);

// ### test/ssc_sram_model.sv
// Purpose: behavioural 16K x 4 static memory
// Assumes: this model resolves the shared data wire
// Notes: no pull-up, so a floating wire shows the inverse of its last value
`timescale 1ns/1ps
module ssc_sram_model
(
    // Memory control
    input wire logic [13:0] addr_i,
    input wire logic sel_n_i,
    input wire logic wr_n_i,
    // Host side of the data wire
    input wire logic host_oe_i,
    input wire logic [3:0] host_d_i,
    // Resolved wire and bus fight flag
    output logic [3:0] pin_o,
    output logic clash_o
);
    logic [3:0] mem [0:16383];
    logic [3:0] q;
    logic [3:0] last = 4'h0;
    logic drv = 1'b0;
    initial clash_o = 1'b0;
    // Strobes move in one step but as separate events: decide after they settle
    always @(sel_n_i or wr_n_i)
    begin
        drv = 1'b0;
        if (!sel_n_i && wr_n_i)
        begin
            #3 drv = !sel_n_i && wr_n_i;
        end
    end
    // Old word kept 3 ns, then garbage until the stored word at 12 ns
    always @(addr_i or negedge sel_n_i)
    begin
        q <= #3 ~mem[addr_i];
        q <= #12 mem[addr_i];
    end
    // Only data the host really drives lands in the array
    always @(sel_n_i or wr_n_i or addr_i or host_oe_i or host_d_i)
        if (!sel_n_i && !wr_n_i && host_oe_i)
            mem[addr_i] = host_d_i;
    assign pin_o = host_oe_i ? host_d_i : drv ? q : ~last;
    always @(pin_o)
        if (host_oe_i || drv)
            last = pin_o;
    always @(host_oe_i or drv)
        if (host_oe_i && drv)
            clash_o = 1'b1;
endmodule // ssc_sram_model

// ### test/ssc_host_tb.sv
// Purpose: self-checking bench for the memory host controller
// Assumes: inputs move 1 ns after each rising edge
// Notes: expectations come from what each scenario wrote
`timescale 1ns/1ps
module ssc_host_tb;
    logic core_clk_i = 1'b0, reset_n_i = 1'b0, req_valid_i = 1'b0, req_write_i = 1'b0;
    logic req_ready_o, rsp_valid_o, mem_select_n_o, mem_write_n_o, mem_data_oe_o, clash;
    logic [13:0] req_addr_i = '0, mem_addr_o;
    logic [3:0] req_wdata_i = '0, rsp_rdata_o, mem_data_o, mem_data_i, q;
    logic [13:0] adr [4] = '{14'h0000, 14'h3FFF, 14'h1555, 14'h2AAA};
    logic [3:0] dat [4] = '{4'h5, 4'hA, 4'hF, 4'h0};
    int miscompares = 0, tests_run = 0, cyc = 0, lat;
    always #2.5 core_clk_i = ~core_clk_i;
    ssc_host u_ssc_host (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
        .rsp_rdata_o(rsp_rdata_o), .mem_addr_o(mem_addr_o),
        .mem_select_n_o(mem_select_n_o), .mem_write_n_o(mem_write_n_o),
        .mem_data_o(mem_data_o), .mem_data_oe_o(mem_data_oe_o), .mem_data_i(mem_data_i));
    ssc_sram_model u_ssc_sram_model (.addr_i(mem_addr_o), .sel_n_i(mem_select_n_o),
        .wr_n_i(mem_write_n_o), .host_oe_i(mem_data_oe_o), .host_d_i(mem_data_o),
        .pin_o(mem_data_i), .clash_o(clash));
    task automatic end_sim();
        if (miscompares == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge core_clk_i)
        if (++cyc == 2000)
        begin
            miscompares++;
            end_sim();
        end
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    // Junk keeps a refused write to the inverted address pending for the first three busy cycles
    task automatic op(input logic w, junk, input logic [13:0] a, input logic [3:0] d);
        int n;
        n = 0;
        // One clean edge first, so no signal moves twice in one step
        @(posedge core_clk_i);
        #1 {req_valid_i, req_write_i, req_addr_i, req_wdata_i} = {1'b1, w, a, d};
        while (req_ready_o !== 1'b1 && n++ < 20)
        begin
            @(posedge core_clk_i);
            #1;
        end
        // Ready seen settled; the request holds through the taking edge
        @(posedge core_clk_i);
        #1 {req_valid_i, req_write_i, req_addr_i} = {junk, 1'b1, ~a};
        for (lat = 1; lat < 20; lat++)
        begin
            @(posedge core_clk_i);
            #1 req_valid_i = junk && lat < 3;
            if (junk)
                check("held address", a, mem_addr_o);
            if ((w ? req_ready_o : rsp_valid_o) === 1'b1)
                break;
        end
        q = rsp_rdata_o;
    endtask
    task automatic t_reset();
        check("reset pins", 4'hC, {mem_select_n_o, mem_write_n_o, mem_data_oe_o, req_ready_o});
    endtask
    task automatic t_corners();
        foreach (adr[i])
        begin
            op(1'b1, 1'b0, adr[i], dat[i]);
            // Setup, three pulse cycles, recovery, then ready
            check("write cycles", 6, lat);
        end
        foreach (adr[i])
        begin
            op(1'b0, 1'b0, adr[i], 4'h0);
            check("read cycles", 6, lat);
            check("read data", dat[i], q);
        end
    endtask
    task automatic t_back();
        op(1'b1, 1'b0, 14'h1234, 4'h3);
        op(1'b1, 1'b0, 14'h1234, 4'hC);
        op(1'b0, 1'b0, 14'h1234, 4'h0);
        check("rewrite data", 4'hC, q);
    endtask
    task automatic t_refused();
        op(1'b0, 1'b1, 14'h3FFF, 4'h0);
        check("busy read", 4'hA, q);
        op(1'b0, 1'b0, 14'h0000, 4'h0);
        check("refused write", 4'h5, q);
        check("bus clash", 1'b0, clash);
    endtask
    initial
    begin
        repeat (16) @(posedge core_clk_i);
        t_reset();
        #1 reset_n_i = 1'b1;
        t_corners();
        t_back();
        t_refused();
        end_sim();
    end
endmodule // ssc_host_tb
